// [verilog/csp8_pkg.sv]
// constants for the 8-bit clocked serial port
// assumes a 250 MHz system clock and word-addressed register indices
package csp8_pkg;
    // ----------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [11:0] IDX_PIN_FUNCTION = 12'h004;
    localparam logic [11:0] IDX_MODE_A = 12'h005;
    localparam logic [11:0] IDX_DATA_LOW = 12'h006;
    localparam logic [11:0] IDX_DATA_HIGH = 12'h007;
    localparam logic [11:0] IDX_DRIVER_CTRL = 12'h00c;
    localparam logic [11:0] IDX_MODE_B = 12'h028;
    localparam logic [11:0] IDX_STATUS = 12'h030;
    localparam logic [11:0] IDX_COMMAND = 12'h031;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int FLAG_BIT = 2;
    localparam int IDLE_LEVEL_BIT = 1;
    localparam int RANGE_BIT = 0;
    localparam int MODEA_EXTCLK_BIT = 3;
    localparam logic [3:0] MODEA_RESET = 4'h0;
    localparam logic [1:0] PINFN_RESET = 2'h0;
    localparam logic [1:0] DRV_RESET = 2'h0;
    localparam logic [2:0] COUNT_ZERO = 3'h0;
    localparam logic [2:0] COUNT_LAST = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int MODEA_SETTLE_CYCLES = 2;
    localparam int DIV_WIDTH = 14;
    typedef enum logic [1:0] {ST_START_WAIT, ST_CLOCK_WAIT, ST_TRANSFER, ST_CONT_CLOCK}
        csp8_state_t;
endpackage

// [verilog/csp8_serial_port.sv]
// 8-bit clocked serial port with AXI4-Lite register slave
// assumes serialClockIn is asynchronous; external pad logic resolves the open pins
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module csp8_serial_port #(
    parameter int DIV_W = csp8_pkg::DIV_WIDTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serialClockIn,
    output logic serialClockOut,
    output logic serialClockOe_n,
    input wire logic serialInputIn,
    output logic serialOutput,
    output logic serialOutputOe_n,
    output logic serialPullupEn,
    output logic serialInterruptFlag
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [1:0] pinFunction_reg;
    logic [3:0] modeA_reg;
    logic [3:0] modeAActive_reg;
    logic [1:0] modeASettle_reg;
    logic [1:0] modeB_reg;
    logic [1:0] driverCtrl_reg;
    logic [7:0] shift_reg;
    logic [2:0] bitCounter_reg;
    logic flag_reg;
    csp8_pkg::csp8_state_t state_reg;
    logic [DIV_W-1:0] div_reg;
    logic intClock_reg;
    logic sckMeta_reg;
    logic sckSync_reg;
    logic sckPrev_reg;
    logic siMeta_reg;
    logic siSync_reg;
    logic firstLow_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [11:0] awIdx_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic [11:0] wrIdx;
    logic [11:0] rdIdx;
    logic doWrite;
    logic modeAWrite;
    logic startCmd;
    logic flagClear;
    logic extClock;
    logic sckLevel;
    logic riseEdge;
    logic fallEdge;
    logic [31:0] wDataCur;
    logic [3:0] wStrbCur;
    logic [DIV_W-1:0] divLimit;

    assign wrIdx = awHeld_reg ? awIdx_reg : s_axi_awaddr[13:2];
    assign rdIdx = s_axi_araddr[13:2];
    // only a completed handshake counts, so a lingering valid never repeats a write
    assign doWrite = (awHeld_reg | (s_axi_awvalid & s_axi_awready))
        & (wHeld_reg | (s_axi_wvalid & s_axi_wready));
    assign modeAWrite = doWrite & (wrIdx == csp8_pkg::IDX_MODE_A) & wStrbCur[0];
    assign startCmd = doWrite & (wrIdx == csp8_pkg::IDX_COMMAND) & wStrbCur[0]
        & wDataCur[0];
    assign flagClear = doWrite & (wrIdx == csp8_pkg::IDX_STATUS) & wStrbCur[0]
        & wDataCur[csp8_pkg::FLAG_BIT];
    assign extClock = modeAActive_reg[csp8_pkg::MODEA_EXTCLK_BIT];
    assign sckLevel = extClock ? sckSync_reg : intClock_reg;
    assign wDataCur = wHeld_reg ? wData_reg : s_axi_wdata;
    assign wStrbCur = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    // address and data are taken in either order and held until both are here
    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awIdx_reg <= 12'h000;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= csp8_pkg::RESP_OKAY;
        end else begin
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wrIdx == csp8_pkg::IDX_PIN_FUNCTION || wrIdx == csp8_pkg::IDX_MODE_A
                    || wrIdx == csp8_pkg::IDX_DATA_LOW || wrIdx == csp8_pkg::IDX_DATA_HIGH
                    || wrIdx == csp8_pkg::IDX_DRIVER_CTRL || wrIdx == csp8_pkg::IDX_MODE_B
                    || wrIdx == csp8_pkg::IDX_STATUS || wrIdx == csp8_pkg::IDX_COMMAND) begin
                    s_axi_bresp <= csp8_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= csp8_pkg::RESP_SLVERR;
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awHeld_reg <= 1'b1;
                    awIdx_reg <= s_axi_awaddr[13:2];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wHeld_reg <= 1'b1;
                    wData_reg <= s_axi_wdata;
                    wStrb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~awHeld_reg & ~s_axi_awready & ~s_axi_bvalid & ~doWrite;
            s_axi_wready <= ~wHeld_reg & ~s_axi_wready & ~s_axi_bvalid & ~doWrite;
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    // write-only registers read as zero but answer okay
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= csp8_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= csp8_pkg::RESP_OKAY;
            if (rdIdx == csp8_pkg::IDX_DATA_LOW) begin
                s_axi_rdata <= {28'h000_0000, shift_reg[3:0]};
            end else if (rdIdx == csp8_pkg::IDX_DATA_HIGH) begin
                s_axi_rdata <= {28'h000_0000, shift_reg[7:4]};
            end else if (rdIdx == csp8_pkg::IDX_STATUS) begin
                s_axi_rdata <= {24'h00_0000, 1'b0, bitCounter_reg, 1'b0, flag_reg,
                    state_reg};
            end else if (rdIdx == csp8_pkg::IDX_PIN_FUNCTION || rdIdx == csp8_pkg::IDX_MODE_A
                || rdIdx == csp8_pkg::IDX_DRIVER_CTRL || rdIdx == csp8_pkg::IDX_MODE_B
                || rdIdx == csp8_pkg::IDX_COMMAND) begin
                s_axi_rdata <= 32'h0000_0000;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= csp8_pkg::RESP_SLVERR;
            end
        end else begin
            s_axi_arready <= s_axi_arvalid;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pinFunction_reg <= csp8_pkg::PINFN_RESET;
            driverCtrl_reg <= csp8_pkg::DRV_RESET;
            modeA_reg <= csp8_pkg::MODEA_RESET;
            modeB_reg[csp8_pkg::RANGE_BIT] <= 1'b0;
        end else if (doWrite && wStrbCur[0]) begin
            if (wrIdx == csp8_pkg::IDX_PIN_FUNCTION) begin
                pinFunction_reg <= wDataCur[1:0];
            end else if (wrIdx == csp8_pkg::IDX_DRIVER_CTRL) begin
                driverCtrl_reg <= wDataCur[1:0];
            end else if (wrIdx == csp8_pkg::IDX_MODE_A) begin
                modeA_reg <= wDataCur[3:0];
            end else if (wrIdx == csp8_pkg::IDX_MODE_B) begin
                modeB_reg[csp8_pkg::RANGE_BIT] <= wDataCur[csp8_pkg::RANGE_BIT];
            end
        end
    end

    // idle level survives reset
    always_ff @(posedge clk) begin
        if (doWrite && wStrbCur[0] && wrIdx == csp8_pkg::IDX_MODE_B) begin
            modeB_reg[csp8_pkg::IDLE_LEVEL_BIT] <= wDataCur[csp8_pkg::IDLE_LEVEL_BIT];
        end
    end

    // mode A reaches the shifter two cycles after the write
    always_ff @(posedge clk) begin
        if (srst) begin
            modeAActive_reg <= csp8_pkg::MODEA_RESET;
            modeASettle_reg <= 2'h0;
        end else if (modeAWrite) begin
            modeASettle_reg <= 2'(csp8_pkg::MODEA_SETTLE_CYCLES - 1);
        end else if (modeASettle_reg != 2'h0) begin
            modeASettle_reg <= modeASettle_reg - 2'h1;
            if (modeASettle_reg == 2'h1) begin
                modeAActive_reg <= modeA_reg;
            end
        end
    end

    // ----------------------------------------
    // serial clock source
    // ----------------------------------------
    // divider ratio 2^(modeA[2:0]*2 + range + 1) system cycles per half period, for modeA[2:0] up to 6
    assign divLimit = DIV_W'((1 << ({modeAActive_reg[2:0], 1'b0}
        + {2'b00, modeB_reg[csp8_pkg::RANGE_BIT]} + 4'h1)) - 1);

    always_ff @(posedge clk) begin
        if (srst) begin
            sckMeta_reg <= 1'b1;
            sckSync_reg <= 1'b1;
            siMeta_reg <= 1'b0;
            siSync_reg <= 1'b0;
        end else begin
            sckMeta_reg <= serialClockIn;
            sckSync_reg <= sckMeta_reg;
            siMeta_reg <= serialInputIn;
            siSync_reg <= siMeta_reg;
        end
    end

    // internal clock runs only while a transfer or continuous clock needs it
    always_ff @(posedge clk) begin
        if (srst || extClock || state_reg == csp8_pkg::ST_START_WAIT) begin
            div_reg <= '0;
            intClock_reg <= 1'b1;
        end else if (div_reg >= divLimit) begin
            div_reg <= '0;
            intClock_reg <= ~intClock_reg;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sckPrev_reg <= 1'b1;
        end else begin
            sckPrev_reg <= sckLevel;
        end
    end

    assign fallEdge = sckPrev_reg & ~sckLevel;
    assign riseEdge = ~sckPrev_reg & sckLevel;

    // ----------------------------------------
    // state machine, counter and shifter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= csp8_pkg::ST_START_WAIT;
            bitCounter_reg <= csp8_pkg::COUNT_ZERO;
            firstLow_reg <= 1'b0;
        end else if (modeAWrite) begin
            state_reg <= csp8_pkg::ST_START_WAIT;
            bitCounter_reg <= csp8_pkg::COUNT_ZERO;
            firstLow_reg <= 1'b0;
        end else begin
            case (state_reg)
                csp8_pkg::ST_START_WAIT: begin
                    if (startCmd) begin
                        state_reg <= csp8_pkg::ST_CLOCK_WAIT;
                        bitCounter_reg <= csp8_pkg::COUNT_ZERO;
                    end
                end
                csp8_pkg::ST_CLOCK_WAIT: begin
                    if (startCmd) begin
                        bitCounter_reg <= csp8_pkg::COUNT_ZERO;
                    end else if (fallEdge) begin
                        if (!extClock && pinFunction_reg == 2'b00) begin
                            state_reg <= csp8_pkg::ST_CONT_CLOCK;
                        end else begin
                            state_reg <= csp8_pkg::ST_TRANSFER;
                            firstLow_reg <= 1'b1;
                        end
                    end
                end
                csp8_pkg::ST_TRANSFER: begin
                    if (startCmd) begin
                        state_reg <= csp8_pkg::ST_CLOCK_WAIT;
                        bitCounter_reg <= csp8_pkg::COUNT_ZERO;
                        firstLow_reg <= 1'b0;
                    end else if (riseEdge) begin
                        firstLow_reg <= 1'b0;
                        bitCounter_reg <= bitCounter_reg + 3'h1;
                        if (bitCounter_reg == csp8_pkg::COUNT_LAST) begin
                            state_reg <= extClock ? csp8_pkg::ST_CLOCK_WAIT
                                : csp8_pkg::ST_START_WAIT;
                        end
                    end
                end
                default: begin
                    bitCounter_reg <= csp8_pkg::COUNT_ZERO;
                end
            endcase
        end
    end

    // shift on the rising edge: sample in and move the next bit out together
    always_ff @(posedge clk) begin
        if (doWrite && wStrbCur[0] && wrIdx == csp8_pkg::IDX_DATA_LOW) begin
            shift_reg[3:0] <= wDataCur[3:0];
        end else if (doWrite && wStrbCur[0] && wrIdx == csp8_pkg::IDX_DATA_HIGH) begin
            shift_reg[7:4] <= wDataCur[3:0];
        end else if (riseEdge && state_reg == csp8_pkg::ST_TRANSFER && !modeAWrite) begin
            shift_reg <= {siSync_reg, shift_reg[7:1]};
        end
    end

    // ----------------------------------------
    // interrupt flag
    // ----------------------------------------
    // set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_reg <= 1'b0;
        end else if (state_reg == csp8_pkg::ST_TRANSFER && !firstLow_reg
            && (modeAWrite || startCmd
            || (riseEdge && bitCounter_reg == csp8_pkg::COUNT_LAST))) begin
            flag_reg <= 1'b1;
        end else if (flagClear) begin
            flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            serialClockOut <= 1'b1;
            serialClockOe_n <= 1'b1;
            serialOutput <= 1'b1;
            serialOutputOe_n <= 1'b1;
            serialPullupEn <= 1'b0;
            serialInterruptFlag <= 1'b0;
        end else begin
            serialClockOut <= intClock_reg;
            serialClockOe_n <= extClock;
            serialOutputOe_n <= ~pinFunction_reg[1];
            serialPullupEn <= driverCtrl_reg[0];
            serialInterruptFlag <= flag_reg;
            if (state_reg == csp8_pkg::ST_START_WAIT) begin
                serialOutput <= modeB_reg[csp8_pkg::IDLE_LEVEL_BIT];
            end else if (state_reg == csp8_pkg::ST_TRANSFER
                || state_reg == csp8_pkg::ST_CLOCK_WAIT) begin
                serialOutput <= shift_reg[0];
            end
        end
    end
endmodule

// [verif/csp8_properties.sv]
// checker for the serial port: bus answers and pin causes
// assumes it is bound to csp8_serial_port and sees only its ports
`timescale 1ns/100ps
module csp8_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic serialClockIn,
    input wire logic serialClockOut,
    input wire logic serialClockOe_n,
    input wire logic serialOutput,
    input wire logic serialPullupEn,
    input wire logic serialInterruptFlag
);
    logic [3:0] quiet_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // ----------
    // cycles since either clock pin moved
    // ----------
    always_ff @(posedge clk) begin
        if (srst || serialClockIn != $past(serialClockIn) || !$stable(serialClockOut)) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hf) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    a_reset_idle: assert property ($fell(srst) |-> !serialInterruptFlag && serialClockOut
        && !s_axi_bvalid) else $error("outputs not idle after reset");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[13:8] != 6'h00
        |=> s_axi_rresp == csp8_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_wo_reads_zero: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr ==
        14'h0010 || s_axi_araddr == 14'h0030) |=> s_axi_rdata == 32'h0000_0000
        && s_axi_rresp == csp8_pkg::RESP_OKAY) else $error("write-only register read back");
    a_pullup_cause: assert property (!$stable(serialPullupEn) |-> s_axi_bvalid
        || $past(s_axi_bvalid)) else $error("pull-up moved without a write");
    a_flag_clear: assert property ($fell(serialInterruptFlag) |-> s_axi_bvalid
        || $past(s_axi_bvalid)) else $error("flag dropped without a write");
    a_shift_cause: assert property (!$stable(serialOutput) |-> s_axi_bvalid
        || $past(s_axi_bvalid) || quiet_reg < 4'h8 || !$stable(serialClockOut)
        || $past(srst) || $past(srst, 2)) else $error("output moved without cause");
    cover property ($rose(serialInterruptFlag));
    cover property (!serialClockOe_n ##1 $fell(serialClockOut));
    cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[13:8] != 6'h00);
endmodule
bind csp8_serial_port csp8_properties csp8_properties_inst (.*);

// [verif/csp8_peer.sv]
// link peer: clock master for framed pulses, data source and sink
// assumes the bench resolves the clock wire from both drivers
`timescale 1ns/100ps
module csp8_peer (
    input wire logic go,
    input wire logic [3:0] pulses,
    input wire logic [7:0] txByte,
    input wire logic sckWire,
    input wire logic serialOutput,
    output logic peerSck,
    output logic sdi,
    output logic busy,
    output logic [7:0] rxByte
);
    int idx = 0;
    initial begin
        peerSck = 1'b1;
        sdi = 1'b0;
        busy = 1'b0;
        rxByte = 8'h00;
    end
    // ----------
    // clock idles high and stands still between frames
    // ----------
    always @(posedge go) begin
        busy = 1'b1;
        idx = 0;
        #1; // keep pin changes off the system clock edges
        repeat (pulses) begin
            #16 peerSck = 1'b0;
            #16 peerSck = 1'b1;
        end
        #16 sdi = ~sdi; // released line must not keep the last bit
        busy = 1'b0;
    end
    always @(negedge sckWire) begin
        sdi = txByte[idx[2:0]];
        idx = idx + 1;
    end
    always @(posedge sckWire) begin
        rxByte = {serialOutput, rxByte[7:1]};
    end
endmodule

// [verif/tb_csp8_serial_port.sv]
// self-checking bench: register calls over AXI4-Lite, link frames from the peer
// assumes responses are always accepted, so bready and rready stay high
`timescale 1ns/100ps
module tb_csp8_serial_port;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, go = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic serialClockOut, serialClockOe_n, serialOutput, serialOutputOe_n;
    logic serialPullupEn, serialInterruptFlag, peerSck, sdi, busy;
    logic [3:0] pulses = 4'h0;
    logic [7:0] txByte = 8'h00, rxByte;
    logic [11:0] woIdx [4] = '{csp8_pkg::IDX_PIN_FUNCTION, csp8_pkg::IDX_MODE_A,
        csp8_pkg::IDX_DRIVER_CTRL, csp8_pkg::IDX_MODE_B};
    int miscompares = 0, total_checks = 0;
    wire logic sckWire = serialClockOe_n ? peerSck : serialClockOut;
    csp8_serial_port csp8_serial_port_inst (.*, .s_axi_wstrb(4'hf), .s_axi_bready(1'b1),
        .s_axi_rready(1'b1), .serialClockIn(sckWire), .serialInputIn(sdi));
    csp8_peer csp8_peer_inst (.*);
    always #2 clk = ~clk;
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang;
        miscompares++;
        end_of_test();
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        int n;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) hang();
        // pins are registered one cycle after the write lands
        @(posedge clk);
    endtask
    task automatic rc(input logic [11:0] idx, input logic [31:0] exp, input bit cmp = 1);
        int n;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 40) hang();
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        if (cmp) chk(rd, exp);
    endtask
    task automatic frame(input logic [3:0] p, input logic [7:0] b);
        int n;
        pulses <= p;
        txByte <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (n = 0; n < 300 && busy; n++) @(posedge clk);
        if (n == 300) hang();
        // the port sees the pin through two flops plus edge detection
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [31:0] st(input logic [2:0] c, input logic f, input logic [1:0] s);
        return {25'h0, c, 1'b0, f, s};
    endfunction
    // ----------
    // main sequence
    // ----------
    initial begin
        int n;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rc(csp8_pkg::IDX_STATUS, st(0, 0, 0));
        foreach (woIdx[i]) rc(woIdx[i], 32'h0000_0000);
        rc(12'h040, 32'h0000_0000);
        chk(32'(rsp), 32'(csp8_pkg::RESP_SLVERR));
        wr(csp8_pkg::IDX_DRIVER_CTRL, 32'h0000_0001);
        chk(serialPullupEn, 1);
        wr(csp8_pkg::IDX_MODE_B, 32'h0000_0000);
        chk(serialOutput, 0);
        wr(csp8_pkg::IDX_MODE_B, 32'h0000_0002);
        chk(serialOutput, 1);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(serialOutput, 1);
        chk(serialPullupEn, 0);
        wr(csp8_pkg::IDX_PIN_FUNCTION, 32'h0000_0003);
        wr(csp8_pkg::IDX_MODE_A, 32'h0000_0008);
        wr(csp8_pkg::IDX_DATA_LOW, 32'h0000_0005);
        wr(csp8_pkg::IDX_DATA_HIGH, 32'h0000_000a);
        chk(serialOutputOe_n, 0);
        frame(3, 8'h00);
        rc(csp8_pkg::IDX_STATUS, st(0, 0, 0));
        wr(csp8_pkg::IDX_COMMAND, 32'h0000_0001);
        rc(csp8_pkg::IDX_STATUS, st(0, 0, 1));
        frame(8, 8'h3c);
        chk(rxByte, 8'ha5);
        rc(csp8_pkg::IDX_STATUS, st(0, 1, 1));
        rc(csp8_pkg::IDX_DATA_LOW, 32'h0000_000c);
        rc(csp8_pkg::IDX_DATA_HIGH, 32'h0000_0003);
        wr(csp8_pkg::IDX_STATUS, 32'h0000_0004);
        chk(serialInterruptFlag, 0);
        wr(csp8_pkg::IDX_COMMAND, 32'h0000_0001);
        frame(9, 8'h00);
        rc(csp8_pkg::IDX_STATUS, st(1, 1, 2));
        wr(csp8_pkg::IDX_STATUS, 32'h0000_0004);
        wr(csp8_pkg::IDX_MODE_A, 32'h0000_0008);
        rc(csp8_pkg::IDX_STATUS, st(0, 1, 0));
        wr(csp8_pkg::IDX_STATUS, 32'h0000_0004);
        wr(csp8_pkg::IDX_COMMAND, 32'h0000_0001);
        frame(3, 8'h00);
        rc(csp8_pkg::IDX_STATUS, st(3, 0, 2));
        wr(csp8_pkg::IDX_COMMAND, 32'h0000_0001);
        rc(csp8_pkg::IDX_STATUS, st(0, 1, 1));
        wr(csp8_pkg::IDX_STATUS, 32'h0000_0004);
        wr(csp8_pkg::IDX_MODE_A, 32'h0000_0008);
        rc(csp8_pkg::IDX_STATUS, st(0, 0, 0));
        // internal clock, slower divider: input data needs its two sync flops before the rise
        wr(csp8_pkg::IDX_MODE_A, 32'h0000_0001);
        wr(csp8_pkg::IDX_DATA_LOW, 32'h0000_0006);
        wr(csp8_pkg::IDX_DATA_HIGH, 32'h0000_0009);
        frame(0, 8'h5a);
        wr(csp8_pkg::IDX_COMMAND, 32'h0000_0001);
        for (n = 0; n < 400 && serialInterruptFlag !== 1'b1; n++) @(posedge clk);
        if (n == 400) hang();
        repeat (20) @(posedge clk);
        chk(serialClockOut, 1);
        chk(rxByte, 8'h96);
        rc(csp8_pkg::IDX_STATUS, st(0, 1, 0));
        rc(csp8_pkg::IDX_DATA_LOW, 32'h0000_000a);
        rc(csp8_pkg::IDX_DATA_HIGH, 32'h0000_0005);
        wr(csp8_pkg::IDX_STATUS, 32'h0000_0004);
        wr(csp8_pkg::IDX_PIN_FUNCTION, 32'h0000_0000);
        wr(csp8_pkg::IDX_MODE_A, 32'h0000_0000);
        wr(csp8_pkg::IDX_COMMAND, 32'h0000_0001);
        repeat (20) @(posedge clk);
        rc(csp8_pkg::IDX_STATUS, 32'h0, 0);
        chk(rd & 32'h0000_0007, 32'h0000_0003);
        for (n = 0; n < 8 && serialClockOut !== 1'b0; n++) @(posedge clk);
        chk(n < 8, 1);
        wr(csp8_pkg::IDX_MODE_A, 32'h0000_0008);
        rc(csp8_pkg::IDX_STATUS, st(0, 0, 0));
        end_of_test();
    end
endmodule
